/* File: mdsp_device.sv */
// Command receiver of the motor driver: shifts words in, commits them
// on strobe fall, locks initialisation addresses and runs the wait period.
// Assumes all link wires and protection pins are asynchronous to sys_clk.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`include "mdsp_params.svh"
module mdsp_device #(
  parameter int WAIT_UNIT_TICKS = `MDSP_WAIT_UNIT_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst,
  mdsp_link_if.device link,
  input wire logic overheat_shutdown,
  input wire logic supply_undervoltage_lock,
  output logic [`MDSP_NUM_ADDR*`MDSP_DATA_W-1:0] setting_flat,
  output logic [`MDSP_NUM_ADDR-1:0] commit_mask,
  output logic bridge_enable,
  output logic wait_busy,
  output logic step_start,
  output logic [2:0] input_mode_serial,
  output logic motor_type_sel,
  output logic pos_ch1_full,
  output logic pos_ch2_full
);
  localparam int IN_SCLK = 0;
  localparam int IN_DATA = 1;
  localparam int IN_STROBE = 2;
  localparam int IN_RSTN = 3;
  localparam int IN_OT = 4;
  localparam int IN_UV = 5;
  localparam int TICK_W = $clog2(`MDSP_TICK_DIV);
  localparam int WAIT_CNT_W = 16;
  localparam int NA = `MDSP_NUM_ADDR;

  logic [5:0] pin_raw;
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;
  logic [`MDSP_WORD_W-2:0] shreg;
  logic [3:0] bit_cnt;
  logic [`MDSP_DATA_W-1:0] settings [NA];
  logic [`MDSP_DATA_W-1:0] pend_data [NA];
  logic [NA-1:0] pend_valid;
  logic [2:0] locked;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic [WAIT_CNT_W-1:0] wait_cnt;
  logic stepped;

  assign pin_raw = {supply_undervoltage_lock, overheat_shutdown,
                    link.active_low_reset_pin, link.word_strobe,
                    link.serial_in_line, link.shift_clk};

  // Two flops on every pin; the second stage and a third, edge-detect stage feed the logic.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      pin_prev <= 6'h00;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic pin_reset;
  logic undervolt;
  logic overheat_act;
  logic halt;
  logic kill;
  logic strobe;
  logic sclk_rise;
  logic strobe_fall;
  logic word_done;
  logic [`MDSP_WORD_W-1:0] word_in;
  logic [`MDSP_ADDR_W-1:0] word_addr;
  logic word_accept;
  logic commit;
  logic [`MDSP_DATA_W-1:0] next_a0;
  logic [WAIT_CNT_W-1:0] next_wait;

  assign pin_reset = ~pin_sync[IN_RSTN];
  assign undervolt = pin_sync[IN_UV];
  // Overheat is disregarded under reset or undervoltage.
  assign overheat_act = pin_sync[IN_OT] & ~pin_reset & ~undervolt;
  assign halt = undervolt | overheat_act;
  // Undervoltage behaves as a full reset so nothing half-stored survives.
  assign kill = rst | pin_reset | undervolt;
  assign strobe = pin_sync[IN_STROBE];
  assign sclk_rise = pin_sync[IN_SCLK] & ~pin_prev[IN_SCLK];
  assign strobe_fall = ~pin_sync[IN_STROBE] & pin_prev[IN_STROBE];
  assign word_done = sclk_rise & strobe & (bit_cnt == 4'hF);
  assign word_in = {pin_sync[IN_DATA], shreg};
  assign word_addr = word_in[`MDSP_WORD_W-1 -: `MDSP_ADDR_W];
  assign word_accept = !(word_addr <= `MDSP_LAST_INIT_ADDR
                         && locked[word_addr[1:0]])
                       && !(wait_busy
                            && word_addr >= `MDSP_FIRST_STEP_ADDR);
  assign commit = strobe_fall & ~halt;
  assign next_a0 = pend_valid[0] ? pend_data[0] : settings[0];
  assign next_wait = WAIT_CNT_W'(next_a0[`MDSP_A0_WAIT_LSB +: `MDSP_A0_WAIT_W]
                     * WAIT_UNIT_TICKS);

  // Shifter samples only on shift clock rise while the strobe is high.
  always_ff @(posedge sys_clk) begin
    if (kill || !strobe) begin
      shreg <= '0;
      bit_cnt <= 4'h0;
    end else if (sclk_rise) begin
      shreg <= word_in[`MDSP_WORD_W-1:1];
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Words are staged per address; a later word overwrites an earlier one
  // and only whole, accepted words ever reach the stage.
  always_ff @(posedge sys_clk) begin
    if (kill || strobe_fall) begin
      pend_valid <= '0;
    end else if (word_done && word_accept) begin
      pend_valid[word_addr] <= 1'b1;
      pend_data[word_addr] <= word_in[`MDSP_DATA_W-1:0];
    end
  end

  // Only staged addresses are written; an empty stage writes nothing.
  always_ff @(posedge sys_clk) begin
    for (int a = 0; a < NA; a++) begin
      if (kill) begin
        settings[a] <= 12'h000;
      end else if (commit && pend_valid[a]) begin
        settings[a] <= pend_data[a];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (kill) begin
      locked <= 3'h0;
    end else if (commit) begin
      locked <= locked | pend_valid[2:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (kill) begin
      commit_mask <= '0;
    end else begin
      commit_mask <= commit ? pend_valid : '0;
    end
  end

  // Reference tick at 5 MHz scales every programmed wait to the clock.
  always_ff @(posedge sys_clk) begin
    if (rst || tick_cnt == TICK_W'(`MDSP_TICK_DIV - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  assign tick = (tick_cnt == TICK_W'(`MDSP_TICK_DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (kill) begin
      wait_busy <= 1'b0;
      wait_cnt <= '0;
      step_start <= 1'b0;
    end else begin
      step_start <= 1'b0;
      if (commit && pend_valid[NA-1:8] != '0) begin
        wait_busy <= 1'b1;
        wait_cnt <= next_wait;
      end else if (wait_busy && tick && !halt) begin
        if (wait_cnt == '0) begin
          wait_busy <= 1'b0;
          step_start <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (kill) begin
      stepped <= 1'b0;
      pos_ch1_full <= 1'b0;
      pos_ch2_full <= 1'b0;
    end else begin
      if (step_start) begin
        stepped <= 1'b1;
      end
      if (!stepped) begin
        pos_ch1_full <= 1'b1;
        pos_ch2_full <= settings[`MDSP_ADDR_STEP_MODE]
                        [`MDSP_STEP_MODE_LSB +: 2]
                        == mdsp_pkg::MDSP_TWO_PHASE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (kill) begin
      bridge_enable <= 1'b0;
    end else begin
      bridge_enable <= ~halt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (kill) begin
      input_mode_serial <= 3'h0;
      motor_type_sel <= 1'b0;
    end else begin
      input_mode_serial <= settings[0][`MDSP_A0_INMODE_LSB +: 3];
      motor_type_sel <= settings[0][`MDSP_A0_MOTOR_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NA; g++) begin : g_flat
      assign setting_flat[g*`MDSP_DATA_W +: `MDSP_DATA_W] = settings[g];
    end
  endgenerate
endmodule

/* File: mdsp_params.svh */
// Constants shared by both ends of the motor driver serial command link.
// Assumes a 40 MHz system clock on both ends.
// Functional notes
// - Sixteen-bit words, bit zero shifted first.
// - Top four bits address, low twelve data.
// - Sample data on shift clock rise, strobe high.
// - Host shifts data only while strobe high.
// - Commit on strobe fall; drop short tails.
// - Many words may share one strobe period.
// - Repeated address: last word wins.
// - Mixed invalid and correct: apply correct only.
// - Empty strobe pulse changes nothing.
// - Unwritten addresses keep their stored value.
// - Commit leaves other addresses' outputs alone.
// - Reset pin low clears settings, bridges off.
// - Words shifted during reset are ignored.
// - Addresses zero to two lock until reset.
// - Host initialises addresses zero to two first.
// - Stepping words during wait are discarded.
// - Addresses three to seven accepted during wait.
// - Stepping starts after wait; others immediately.
// - Start position depends on drive mode.
// - Timing derives from clock, scaled to 5 MHz.
// - Overheat stops all, unless reset or undervoltage.
// - Undervoltage stops the whole device.
// - Address zero: input modes, motor type, wait.
`ifndef MDSP_PARAMS_SVH
`define MDSP_PARAMS_SVH
`define MDSP_WORD_W 16
`define MDSP_ADDR_W 4
`define MDSP_DATA_W 12
`define MDSP_NUM_ADDR 16
`define MDSP_LAST_INIT_ADDR 4'h2
`define MDSP_FIRST_STEP_ADDR 4'h8
`define MDSP_ADDR_STEP_MODE 4'h8
`define MDSP_A0_WAIT_LSB 0
`define MDSP_A0_WAIT_W 6
`define MDSP_A0_MOTOR_BIT 6
`define MDSP_A0_INMODE_LSB 7
`define MDSP_STEP_MODE_LSB 8
`define MDSP_CLK_MHZ 40
`define MDSP_REF_MHZ 5
`define MDSP_TICK_DIV (`MDSP_CLK_MHZ / `MDSP_REF_MHZ)
`define MDSP_WAIT_UNIT_TICKS 50
`define MDSP_SCLK_HALF 4
`define MDSP_REG_DATA 8'h00
`define MDSP_REG_CTRL 8'h04
`define MDSP_REG_STATUS 8'h08
`define MDSP_CTRL_RELEASE 0
`define MDSP_CTRL_KEEP_OPEN 1
`endif

/* File: mdsp_pkg.sv */
// Types shared by both ends of the serial command link.
// Assumes mdsp_params.svh is compiled alongside.
package mdsp_pkg;
  typedef enum logic [1:0] {
    MDSP_MICRO_STEP,
    MDSP_HALF_STEP,
    MDSP_TWO_PHASE,
    MDSP_MODE_SPARE
  } mdsp_step_mode_t;
  typedef enum {
    MDSP_H_IDLE,
    MDSP_H_OPEN,
    MDSP_H_LOW,
    MDSP_H_HIGH,
    MDSP_H_CLOSE
  } mdsp_host_state_t;
endpackage

/* File: mdsp_link_if.sv */
// Four-wire command link between the host controller and the driver.
// All wires are driven by the host; the device only listens.
interface mdsp_link_if;
  logic shift_clk;
  logic serial_in_line;
  logic word_strobe;
  logic active_low_reset_pin;
  modport device (
    input shift_clk,
    input serial_in_line,
    input word_strobe,
    input active_low_reset_pin
  );
  modport host (
    output shift_clk,
    output serial_in_line,
    output word_strobe,
    output active_low_reset_pin
  );
endinterface

/* File: mdsp_host.sv */
// Host end of the command link: a Wishbone slave takes words from
// software and shifts them out; software steers the strobe and reset pin.
// Assumes a classic Wishbone master on the same 40 MHz clock.
`include "mdsp_params.svh"
module mdsp_host #(
  parameter int SCLK_HALF = `MDSP_SCLK_HALF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  mdsp_link_if.host link
);
  mdsp_pkg::mdsp_host_state_t state;
  logic [1:0] ctrl;
  logic [15:0] tx_word;
  logic [3:0] tx_bit;
  logic [7:0] half_cnt;
  logic half_tick;
  logic [2:0] init_seen;
  logic refused;
  logic req;
  logic data_wr;
  logic launch;
  logic busy;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign data_wr = req & wb_we_i & (wb_adr_i == `MDSP_REG_DATA) & wb_sel_i[0]
                   & wb_sel_i[1];
  assign busy = (state != mdsp_pkg::MDSP_H_IDLE);
  // Driving words are refused until all three initialisation words have been launched.
  assign launch = data_wr & ~busy & ctrl[`MDSP_CTRL_RELEASE]
                  & ((wb_dat_i[15:12] <= `MDSP_LAST_INIT_ADDR)
                     | (&init_seen));
  assign half_tick = (half_cnt == 8'(SCLK_HALF - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i && wb_adr_i == `MDSP_REG_CTRL) begin
        wb_dat_o <= {30'h0000_0000, ctrl};
      end else if (req && !wb_we_i && wb_adr_i == `MDSP_REG_STATUS) begin
        wb_dat_o <= {28'h000_0000, refused, &init_seen,
                     link.word_strobe, busy};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= 2'h0;
    end else if (req && wb_we_i && wb_adr_i == `MDSP_REG_CTRL
                 && wb_sel_i[0]) begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refused <= 1'b0;
    end else if (data_wr) begin
      refused <= ~launch;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !ctrl[`MDSP_CTRL_RELEASE]) begin
      init_seen <= 3'h0;
    end else if (launch && wb_dat_i[15:12] <= `MDSP_LAST_INIT_ADDR) begin
      init_seen[wb_dat_i[13:12]] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !busy || half_tick) begin
      half_cnt <= 8'h00;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.active_low_reset_pin <= 1'b0;
    end else begin
      link.active_low_reset_pin <= ctrl[`MDSP_CTRL_RELEASE];
    end
  end

  // Data only moves while the strobe is high; bit zero leaves first.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= mdsp_pkg::MDSP_H_IDLE;
      link.shift_clk <= 1'b0;
      link.serial_in_line <= 1'b0;
      link.word_strobe <= 1'b0;
      tx_word <= 16'h0000;
      tx_bit <= 4'h0;
    end else begin
      unique case (state)
        mdsp_pkg::MDSP_H_IDLE: begin
          if (launch) begin
            tx_word <= wb_dat_i[15:0];
            tx_bit <= 4'h0;
            link.word_strobe <= 1'b1;
            state <= mdsp_pkg::MDSP_H_OPEN;
          end else if (link.word_strobe && !ctrl[`MDSP_CTRL_KEEP_OPEN]) begin
            state <= mdsp_pkg::MDSP_H_CLOSE;
          end
        end
        mdsp_pkg::MDSP_H_OPEN: begin
          link.serial_in_line <= tx_word[0];
          state <= mdsp_pkg::MDSP_H_LOW;
        end
        mdsp_pkg::MDSP_H_LOW: begin
          if (half_tick) begin
            link.shift_clk <= 1'b1;
            state <= mdsp_pkg::MDSP_H_HIGH;
          end
        end
        mdsp_pkg::MDSP_H_HIGH: begin
          if (half_tick) begin
            link.shift_clk <= 1'b0;
            if (tx_bit == 4'hF) begin
              state <= mdsp_pkg::MDSP_H_IDLE;
            end else begin
              tx_bit <= tx_bit + 4'h1;
              link.serial_in_line <= tx_word[tx_bit + 4'h1];
              state <= mdsp_pkg::MDSP_H_LOW;
            end
          end
        end
        mdsp_pkg::MDSP_H_CLOSE: begin
          link.word_strobe <= 1'b0;
          state <= mdsp_pkg::MDSP_H_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: mdsp_link_chk.sv */
// Checker on the command link wires between the host and device ends.
// Assumes one sys_clk domain and a synchronous active-high reset.
module mdsp_link_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic serial_in_line,
  input wire logic word_strobe,
  input wire logic active_low_reset_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] bits;
  // Counts rises modulo 16, so only whole words leave zero at the fall.
  always_ff @(posedge sys_clk) begin
    if (rst || !word_strobe) begin
      bits <= 4'h0;
    end else if ($rose(shift_clk)) begin
      bits <= bits + 4'h1;
    end
  end
  a_shift_in_strobe:
    assert property ($rose(shift_clk) |-> word_strobe)
    else $error("Shift clock rose with strobe low.");
  a_data_settled:
    assert property ($rose(shift_clk) |-> $stable(serial_in_line))
    else $error("Data moved at the sampling rise.");
  a_high_half:
    assert property ($rose(shift_clk) |-> shift_clk [*4])
    else $error("Shift clock high phase is not four cycles.");
  a_low_half:
    assert property ($fell(shift_clk) && word_strobe |-> !shift_clk [*4])
    else $error("Shift clock low phase is too short.");
  a_whole_words:
    assert property ($fell(word_strobe) |-> bits == 4'h0)
    else $error("Strobe closed on a partial word.");
  a_close_clk_low:
    assert property ($fell(word_strobe) |-> !$past(shift_clk, 2))
    else $error("Strobe fell too soon after the last bit.");
  a_open_clk_low:
    assert property ($rose(word_strobe) |-> !shift_clk [*4])
    else $error("Shift clock rose too soon after strobe rise.");
  a_release_quiet:
    assert property ($fell(rst) |->
      !word_strobe && !shift_clk && !active_low_reset_pin)
    else $error("Link wires not idle after reset.");
  a_strobe_pin_up:
    assert property (word_strobe |-> active_low_reset_pin)
    else $error("Strobe high while device held in reset.");
  cover property ($fell(word_strobe));
  cover property ($rose(active_low_reset_pin));
  cover property ($fell(active_low_reset_pin));
endmodule

/* File: motor_driver_serial_command_port_test.sv */
// Bench: a Wishbone master drives the host end, which feeds the device;
// a second device is driven by raw pin waveforms no host would send.
// Assumes WAIT_UNIT_TICKS of 1 so stepping waits stay short.
`include "mdsp_params.svh"
module motor_driver_serial_command_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, cyc, stb, we, ack, ot, uv, be, wt, ss, mts, p1, p2;
  logic pend;
  logic [2:0] ims;
  logic [3:0] sel;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd, v;
  logic [15:0] cm, cm2, last2;
  logic [191:0] flat, flat2;
  logic [207:0] cur;
  logic [207:0] q[$];
  logic [15:0] ws[$];
  logic [11:0] m[16];
  logic [1:0] md;
  int n_fail, num_checks, n2, n;
  mdsp_link_if link();
  mdsp_link_if link2();
  mdsp_host #(.SCLK_HALF(4)) mdsp_host_i (.sys_clk, .rst,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(link.host));
  mdsp_device #(.WAIT_UNIT_TICKS(1)) mdsp_device_i (.sys_clk, .rst,
    .link(link.device), .overheat_shutdown(ot),
    .supply_undervoltage_lock(uv), .setting_flat(flat), .commit_mask(cm),
    .bridge_enable(be), .wait_busy(wt), .step_start(ss),
    .input_mode_serial(ims), .motor_type_sel(mts), .pos_ch1_full(p1),
    .pos_ch2_full(p2));
  mdsp_device #(.WAIT_UNIT_TICKS(1)) mdsp_device_i2 (.sys_clk, .rst,
    .link(link2.device), .overheat_shutdown(1'b0),
    .supply_undervoltage_lock(1'b0), .setting_flat(flat2),
    .commit_mask(cm2), .bridge_enable(), .wait_busy(), .step_start(),
    .input_mode_serial(), .motor_type_sel(), .pos_ch1_full(),
    .pos_ch2_full());
  mdsp_link_chk mdsp_link_chk_i (.sys_clk, .rst,
    .shift_clk(link.shift_clk), .serial_in_line(link.serial_in_line),
    .word_strobe(link.word_strobe),
    .active_low_reset_pin(link.active_low_reset_pin));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d.", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [191:0] e, s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic give_up(input logic bad);
    if (bad !== 1'b0) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    give_up(ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic poll(input logic [1:0] mk);
    int k;
    k = 0;
    do begin
      wbx(1'b0, `MDSP_REG_STATUS, 32'h0);
      k++;
    end while ((rd[1:0] & mk) !== 2'b00 && k < 300);
    give_up((rd[1:0] & mk) !== 2'b00);
  endtask
  // Keep-open is cleared while the last word shifts, so the whole queue
  // shares one strobe period and commits together.
  task automatic burst;
    wbx(1'b1, `MDSP_REG_CTRL, 32'h3);
    foreach (ws[i]) begin
      wbx(1'b1, `MDSP_REG_DATA, {16'h0, ws[i]});
      if (i == ws.size() - 1) wbx(1'b1, `MDSP_REG_CTRL, 32'h1);
      poll(2'b01);
    end
    poll(2'b10);
    repeat (8) @(posedge sys_clk);
  endtask
  function automatic logic [191:0] fl;
    for (int a = 0; a < 16; a++) fl[a*12 +: 12] = m[a];
  endfunction
  task automatic note(input logic [15:0] k);
    q.push_back({k, fl()});
  endtask
  // Settings are compared one cycle after the commit pulse.
  always @(posedge sys_clk) begin
    if (pend) chk("settings", cur[191:0], flat);
    pend = 1'b0;
    if (!rst && cm !== 16'h0) begin
      cur = q.size() > 0 ? q.pop_front() : '1;
      chk("commit mask", cur[207:192], cm);
      pend = 1'b1;
    end
  end
  always @(posedge sys_clk) begin
    if (!rst && cm2 !== 16'h0) begin
      n2++;
      last2 = cm2;
    end
  end
  task automatic raw(input logic [15:0] w, input int nb);
    for (int i = 0; i < nb; i++) begin
      link2.serial_in_line <= w[i];
      repeat (4) @(posedge sys_clk);
      link2.shift_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      link2.shift_clk <= 1'b0;
    end
  endtask
  task automatic stb2(input logic s);
    @(posedge sys_clk);
    link2.word_strobe <= s;
    link2.serial_in_line <= ~link2.serial_in_line;
    repeat (6) @(posedge sys_clk);
  endtask
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    ot = 1'b0;
    uv = 1'b0;
    pend = 1'b0;
    n2 = 0;
    n_fail = 0;
    num_checks = 0;
    link2.shift_clk = 1'b0;
    link2.serial_in_line = 1'b0;
    link2.word_strobe = 1'b0;
    link2.active_low_reset_pin = 1'b0;
    foreach (m[i]) m[i] = 12'h000;
    v = $urandom(32'hFECC5F5F);
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("reset settings", 192'h0, flat);
    chk("bridge enable", 1'b0, be);
    $display("Reset test done.");
    wbx(1'b1, `MDSP_REG_CTRL, 32'h1);
    repeat (6) @(posedge sys_clk);
    chk("bridge on", 1'b1, be);
    wbx(1'b1, `MDSP_REG_DATA, 32'h5ABC);
    wbx(1'b0, `MDSP_REG_STATUS, 32'h0);
    chk("early refusal", 1'b1, rd[3]);
    $display("Order test done.");
    v = $urandom;
    m[0] = {2'b00, v[3:0], 6'h3F};
    m[1] = {3'b000, v[24:16]};
    note(16'h0007);
    ws = '{16'h0001, {4'h1, m[1]}, 16'h2000, {4'h0, m[0]}};
    burst();
    chk("input mode", m[0][9:7], ims);
    chk("motor type", m[0][6], mts);
    m[3] = {4'h0, v[11:7], 1'b0, v[5:4]};
    note(16'h0008);
    ws = '{16'h0040, 16'h10FF, {4'h3, m[3]}};
    burst();
    $display("Init and lock tests done.");
    md = 2'($urandom_range(2, 0));
    m[8] = {2'b00, md, v[15:8]};
    note(16'h0100);
    ws = '{{4'h8, m[8]}};
    burst();
    m[5] = {4'h0, v[23:16]};
    note(16'h0020);
    ws = '{16'h9123, {4'h5, m[5]}};
    burst();
    chk("still waiting", 1'b1, wt);
    n = 0;
    while (ss !== 1'b1 && n < 1000) begin
      @(posedge sys_clk);
      n++;
    end
    give_up(ss !== 1'b1);
    repeat (2) @(posedge sys_clk);
    chk("ch1 start", 1'b1, p1);
    chk("ch2 start", md == 2'd2, p2);
    $display("Wait test done.");
    ot <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("overheat bridge", 1'b0, be);
    ws = '{16'h40AA};
    burst();
    chk("overheat hold", fl(), flat);
    ot <= 1'b0;
    wbx(1'b1, `MDSP_REG_CTRL, 32'h0);
    repeat (6) @(posedge sys_clk);
    foreach (m[i]) m[i] = 12'h000;
    chk("pin reset", fl(), flat);
    wbx(1'b1, `MDSP_REG_CTRL, 32'h1);
    repeat (6) @(posedge sys_clk);
    m[0] = 12'h005;
    note(16'h0007);
    ws = '{16'h0005, 16'h1000, 16'h2000};
    burst();
    uv <= 1'b1;
    repeat (6) @(posedge sys_clk);
    m[0] = 12'h000;
    chk("undervoltage", fl(), flat);
    chk("uv bridge", 1'b0, be);
    uv <= 1'b0;
    $display("Protection tests done.");
    stb2(1'b1);
    raw(16'h32BC, 16);
    stb2(1'b0);
    link2.active_low_reset_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("reset shifting", 0, n2);
    stb2(1'b1);
    raw(16'h02BC, 16);
    raw(16'h1DEF, 5);
    stb2(1'b0);
    chk("tail mask", 16'h0001, last2);
    chk("tail data", 12'h2BC, flat2[11:0]);
    stb2(1'b1);
    stb2(1'b0);
    chk("empty strobe", 1, n2);
    chk("empty hold", 12'h2BC, flat2[11:0]);
    $display("Raw link tests done.");
    end_sim();
  end
endmodule
